// >>> logic/mbx_top.sv
module mbx_top
   import mbx_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   // Device side (internal engine) port.
   input wire logic dev_take_i,
   output logic host_msg_pending_flag_o,
   output logic [7:0] host_to_dev_status_reg_o,
   output logic [15:0] host_cw_o,
   input wire logic [5:0] dev_rd_idx_i,
   output logic [7:0] host_mbx_byte_o,
   input wire logic dev_send_i,
   input wire logic [7:0] dev_status_i,
   input wire logic [15:0] dev_cw_i,
   input wire logic dev_mbx_we_i,
   input wire logic [5:0] dev_mbx_idx_i,
   input wire logic [7:0] dev_mbx_data_i,
   output logic dev_msg_pending_flag_o,
   output logic dev_send_ok_o,
   output logic [1:0] op_channel_o,
   output logic [1:0] op_kind_o,
   output logic [1:0] ch1_route_o,
   output logic [1:0] ch2_route_o,
   output logic [1:0] ch1_frame_o,
   output logic [1:0] ch2_frame_o
);
   // ==========================================================
   // Storage: one memory per direction behind a single data address.
   logic [7:0] host_mbx [MBX_DEPTH];
   logic [7:0] dev_mbx [MBX_DEPTH];
   logic [5:0] wr_addr;
   logic [5:0] rd_addr;
   logic host_msg_pending_flag;
   logic dev_msg_pending_flag;
   logic [7:0] host_to_dev_status_reg;
   logic [7:0] dev_to_host_status_reg;
   logic [15:0] host_cw;
   logic [15:0] dev_cw;
   logic irq_mask_bit;
   logic irq_pending_bit;
   logic [1:0] ch1_route;
   logic [1:0] ch2_route;
   logic [1:0] ch1_frame;
   logic [1:0] ch2_frame;
   logic [7:0] rdata;
   logic wr_data;
   logic rd_data;

   assign wr_data = wr_i && (addr_i == ADR_MBX_DATA);
   assign rd_data = rd_i && (addr_i == ADR_MBX_DATA);

   // ==========================================================
   // Mailboxes: host bytes through the auto-incrementing address, device bytes by index while not pending.
   generate
      for (genvar g = 0; g < MBX_DEPTH; g++) begin : g_hmbx
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               host_mbx[g] <= RST_BYTE;
            end else if (wr_data && wr_addr == 6'(g)) begin
               host_mbx[g] <= wdata_i;
            end
         end
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               dev_mbx[g] <= RST_BYTE;
            end else if (dev_mbx_we_i && !dev_msg_pending_flag && dev_mbx_idx_i == 6'(g)) begin
               dev_mbx[g] <= dev_mbx_data_i;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Address registers. Past the last byte the address stays put, so a
   // runaway host overwrites the final byte instead of wrapping.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_addr <= 6'h00;
      end else if (wr_i && addr_i == ADR_WR_ADDR) begin
         // An address past the last byte is clamped so no access leaves the memory.
         wr_addr <= (wdata_i[5:0] > MBX_LAST) ? MBX_LAST : wdata_i[5:0];
      end else if (wr_data && wr_addr != MBX_LAST) begin
         wr_addr <= wr_addr + 6'h01;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_addr <= 6'h00;
      end else if (wr_i && addr_i == ADR_RD_ADDR) begin
         rd_addr <= (wdata_i[5:0] > MBX_LAST) ? MBX_LAST : wdata_i[5:0];
      end else if (rd_data && rd_addr != MBX_LAST) begin
         rd_addr <= rd_addr + 6'h01;
      end
   end

   // ==========================================================
   // Host to device message.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         host_cw <= 16'h0000;
      end else if (wr_i && addr_i == ADR_HOST_CW_HI) begin
         host_cw[15:8] <= wdata_i;
      end else if (wr_i && addr_i == ADR_HOST_CW_LO) begin
         host_cw[7:0] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         host_to_dev_status_reg <= RST_BYTE;
      end else if (wr_i && addr_i == ADR_HOST_STATUS) begin
         host_to_dev_status_reg <= wdata_i;
      end
   end

   // A status write in the same cycle as the device release keeps the flag set.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         host_msg_pending_flag <= 1'b0;
      end else if (wr_i && addr_i == ADR_HOST_STATUS) begin
         host_msg_pending_flag <= 1'b1;
      end else if (dev_take_i) begin
         host_msg_pending_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Operation decode and per-channel routing set by config operations.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ch1_route <= MBX_RT_BYPASS;
         ch2_route <= MBX_RT_BYPASS;
         ch1_frame <= MBX_FR_OFF;
         ch2_frame <= MBX_FR_OFF;
      end else if (dev_take_i && host_msg_pending_flag &&
                   host_to_dev_status_reg[OP_KIND_LSB +: 2] == OP_CFG) begin
         unique case (host_to_dev_status_reg[OP_CH_LSB +: 2])
            2'h1: begin
               ch1_route <= host_cw[9:8];
               ch1_frame <= host_cw[11:10];
            end
            2'h2: begin
               // Channel 2 has no modem or tone path; those fall back to bypass.
               ch2_route <= (host_cw[9:8] == MBX_RT_RATE) ? MBX_RT_RATE
                                                           : MBX_RT_BYPASS;
               ch2_frame <= host_cw[11:10];
            end
            default: begin
               ch1_route <= ch1_route;
            end
         endcase
      end
   end

   // ==========================================================
   // Device to host message. Sends are refused while the host owns it.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dev_to_host_status_reg <= RST_BYTE;
         dev_cw <= 16'h0000;
      end else if (dev_send_i && !dev_msg_pending_flag) begin
         dev_to_host_status_reg <= dev_status_i;
         dev_cw <= dev_cw_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dev_msg_pending_flag <= 1'b0;
      end else if (dev_send_i && !dev_msg_pending_flag) begin
         dev_msg_pending_flag <= 1'b1;
      end else if (wr_i && addr_i == ADR_DEV_FLAG && !wdata_i[0]) begin
         dev_msg_pending_flag <= 1'b0;
      end
   end

   assign irq_pending_bit = dev_msg_pending_flag;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_mask_bit <= RST_MASK;
      end else if (wr_i && addr_i == ADR_IRQ) begin
         irq_mask_bit <= wdata_i[IRQ_BIT];
      end
   end

   // ==========================================================
   // Host read data, one cycle after the read strobe.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata <= RST_BYTE;
      end else if (rd_i) begin
         unique case (addr_i)
            ADR_MBX_DATA: rdata <= dev_mbx[rd_addr];
            ADR_HOST_FLAG: rdata <= {7'h00, host_msg_pending_flag};
            ADR_HOST_CW_HI: rdata <= host_cw[15:8];
            ADR_HOST_CW_LO: rdata <= host_cw[7:0];
            ADR_WR_ADDR: rdata <= {2'h0, wr_addr};
            ADR_DEV_STATUS: rdata <= dev_to_host_status_reg;
            ADR_DEV_FLAG: rdata <= {7'h00, dev_msg_pending_flag};
            ADR_DEV_CW_HI: rdata <= dev_cw[15:8];
            ADR_DEV_CW_LO: rdata <= dev_cw[7:0];
            ADR_RD_ADDR: rdata <= {2'h0, rd_addr};
            ADR_IRQ: rdata <= 8'(irq_pending_bit) << IRQ_BIT;
            default: rdata <= RST_BYTE;
         endcase
      end else begin
         rdata <= RST_BYTE;
      end
   end

   assign rdata_o = rdata;
   assign irq_o = irq_pending_bit && irq_mask_bit;
   assign host_msg_pending_flag_o = host_msg_pending_flag;
   assign host_to_dev_status_reg_o = host_to_dev_status_reg;
   assign host_cw_o = host_cw;
   assign host_mbx_byte_o = (dev_rd_idx_i > MBX_LAST) ? RST_BYTE : host_mbx[dev_rd_idx_i];
   assign dev_msg_pending_flag_o = dev_msg_pending_flag;
   assign dev_send_ok_o = !dev_msg_pending_flag;
   assign op_channel_o = host_to_dev_status_reg[OP_CH_LSB +: 2];
   assign op_kind_o = host_to_dev_status_reg[OP_KIND_LSB +: 2];
   assign ch1_route_o = ch1_route;
   assign ch2_route_o = ch2_route;
   assign ch1_frame_o = ch1_frame;
   assign ch2_frame_o = ch2_frame;
endmodule : mbx_top

// >>> logic/mbx_pkg.sv
// What this block does
// - Host write of its status register sets the host pending flag.
// - Device clears host pending flag after reading the message.
// - Host control word: high byte control info, low byte valid byte count.
// - Device control word: high byte control info, low byte valid byte count.
// - Device waits for its pending flag clear before sending a message.
// - Device writes word and mailbox first; status write sets flag and interrupt.
// - Interrupt driven only while mask is one; pending bit set regardless.
// - Channel 1 routes to modem, rate formatter, tone unit or transparent.
// - Channel 2 routes only to rate formatter or transparent.
// - Both channels pass through a framing unit with per-channel mode.
// - Framing adds async bits, HDLC handling, or binary passthrough.
// - Every buffer operation is selected by the written status byte.
// - Interrupt mask is zero after reset.
// - Mailbox address increments after every host mailbox data access, except at the last byte, where it stays put.
// - Two separate 61-byte mailboxes share one host data address.
package mbx_pkg;
   // ==========================================================
   // Host register map
   localparam logic [7:0] ADR_MBX_DATA = 8'h00;
   localparam logic [7:0] ADR_HOST_STATUS = 8'h50;
   localparam logic [7:0] ADR_HOST_FLAG = 8'h51;
   localparam logic [7:0] ADR_HOST_CW_HI = 8'h52;
   localparam logic [7:0] ADR_HOST_CW_LO = 8'h53;
   localparam logic [7:0] ADR_WR_ADDR = 8'h54;
   localparam logic [7:0] ADR_DEV_STATUS = 8'h58;
   localparam logic [7:0] ADR_DEV_FLAG = 8'h59;
   localparam logic [7:0] ADR_DEV_CW_HI = 8'h5a;
   localparam logic [7:0] ADR_DEV_CW_LO = 8'h5b;
   localparam logic [7:0] ADR_RD_ADDR = 8'h5c;
   localparam logic [7:0] ADR_IRQ = 8'h75;
   localparam int IRQ_BIT = 2;
   localparam int MBX_DEPTH = 61;
   localparam logic [5:0] MBX_LAST = 6'h3c;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic RST_MASK = 1'b0;
   // ==========================================================
   // Status byte selection of the buffer operation.
   localparam int OP_CH_LSB = 6;
   localparam int OP_KIND_LSB = 4;
   localparam logic [1:0] OP_CFG = 2'h0;
   localparam logic [1:0] OP_STAT = 2'h1;
   localparam logic [1:0] OP_DATA = 2'h2;
   // ==========================================================
   // Channel routing and framing modes.
   typedef enum logic [1:0] {
      MBX_RT_MODEM, MBX_RT_RATE, MBX_RT_TONE, MBX_RT_BYPASS
   } mbx_route_t;
   typedef enum logic [1:0] {
      MBX_FR_OFF, MBX_FR_ASYNC, MBX_FR_HDLC, MBX_FR_BIN
   } mbx_frame_t;
endpackage : mbx_pkg

// >>> bench/mbx_chk_sva.sv
module mbx_chk
   import mbx_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic irq_o,
   input wire logic dev_take_i,
   input wire logic host_msg_pending_flag_o,
   input wire logic [15:0] host_cw_o,
   input wire logic dev_send_i,
   input wire logic dev_msg_pending_flag_o,
   input wire logic dev_send_ok_o,
   input wire logic [1:0] op_channel_o,
   input wire logic [1:0] op_kind_o,
   input wire logic [1:0] ch2_route_o
);
   // ==========================================================
   // Mask shadow.
   // The mask is not a port, so it is rebuilt from host writes.
   logic mask;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mask <= RST_MASK;
      end else if (wr_i && addr_i == ADR_IRQ) begin
         mask <= wdata_i[IRQ_BIT];
      end
   end
   // ==========================================================
   // Properties.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   host_flag_set_a: assert property (wr_i && addr_i == ADR_HOST_STATUS |=> host_msg_pending_flag_o)
      else $error("host flag not set by status write");
   host_flag_clr_a: assert property (dev_take_i && !(wr_i && addr_i == ADR_HOST_STATUS)
      |=> !host_msg_pending_flag_o) else $error("host flag not cleared by take");
   host_cw_low_a: assert property (wr_i && addr_i == ADR_HOST_CW_LO
      |=> host_cw_o[7:0] == $past(wdata_i)) else $error("host count byte wrong");
   dev_send_ok_a: assert property (dev_send_ok_o == !dev_msg_pending_flag_o)
      else $error("send ok disagrees with flag");
   dev_flag_set_a: assert property (dev_send_i && !dev_msg_pending_flag_o |=> dev_msg_pending_flag_o)
      else $error("device flag not set by send");
   irq_level_a: assert property (irq_o == (dev_msg_pending_flag_o && mask))
      else $error("irq level wrong");
   pend_read_a: assert property (rd_i && addr_i == ADR_IRQ
      |=> rdata_o[IRQ_BIT] == $past(dev_msg_pending_flag_o)) else $error("pending bit wrong");
   dev_release_a: assert property (wr_i && addr_i == ADR_DEV_FLAG && !wdata_i[0] && !dev_send_i
      |=> !dev_msg_pending_flag_o) else $error("device flag not released");
   ch2_route_a: assert property (ch2_route_o == MBX_RT_RATE || ch2_route_o == MBX_RT_BYPASS)
      else $error("channel 2 route illegal");
   op_field_a: assert property (wr_i && addr_i == ADR_HOST_STATUS
      |=> {op_channel_o, op_kind_o} == $past(wdata_i[7:4])) else $error("operation fields wrong");
endmodule : mbx_chk

bind mbx_top mbx_chk u_mbx_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .dev_take_i(dev_take_i),
   .host_msg_pending_flag_o(host_msg_pending_flag_o), .host_cw_o(host_cw_o),
   .dev_send_i(dev_send_i), .dev_msg_pending_flag_o(dev_msg_pending_flag_o),
   .dev_send_ok_o(dev_send_ok_o), .op_channel_o(op_channel_o), .op_kind_o(op_kind_o),
   .ch2_route_o(ch2_route_o));

// >>> bench/mbx_host.sv
module mbx_host
   import mbx_pkg::*;
(
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // ==========================================================
   // Bus cycles.
   // Idle address and data are inverted so stale values never look valid.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
      #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask : rd_reg
   // ==========================================================
   // Host message: wait for a free mailbox, then word, bytes, status last.
   task automatic send_msg(input logic [7:0] st, input logic [15:0] cw, input logic [7:0] b0,
      input logic [7:0] b1);
      logic [7:0] f;
      int n;
      f = 8'h01;
      n = 0;
      while (f[0] !== 1'b0 && n < 50) begin
         rd_reg(ADR_HOST_FLAG, f);
         n++;
      end
      wr_reg(ADR_HOST_CW_HI, cw[15:8]);
      wr_reg(ADR_HOST_CW_LO, cw[7:0]);
      wr_reg(ADR_WR_ADDR, 8'h00);
      wr_reg(ADR_MBX_DATA, b0);
      wr_reg(ADR_MBX_DATA, b1);
      wr_reg(ADR_HOST_STATUS, st);
   endtask : send_msg
endmodule : mbx_host

// >>> bench/tb_mbx_top.sv
module tb_mbx_top
   import mbx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr_i, rd_i, irq_o, host_msg_pending_flag_o, dev_msg_pending_flag_o, dev_send_ok_o;
   logic dev_take_i = 1'b0;
   logic dev_send_i = 1'b0;
   logic dev_mbx_we_i = 1'b0;
   logic [5:0] dev_rd_idx_i = 6'h00;
   logic [5:0] dev_mbx_idx_i = 6'h00;
   logic [7:0] addr_i, wdata_i, rdata_o, host_to_dev_status_reg_o, host_mbx_byte_o, d;
   logic [7:0] dev_status_i = 8'h00;
   logic [7:0] dev_mbx_data_i = 8'h00;
   logic [15:0] host_cw_o;
   logic [15:0] dev_cw_i = 16'h0000;
   logic [1:0] op_channel_o, op_kind_o, ch1_route_o, ch2_route_o, ch1_frame_o, ch2_frame_o;
   int n_fail = 0;
   int checks = 0;
   always #20 clk_i = ~clk_i;
   mbx_top u_mbx_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .dev_take_i(dev_take_i),
      .host_msg_pending_flag_o(host_msg_pending_flag_o), .host_cw_o(host_cw_o),
      .host_to_dev_status_reg_o(host_to_dev_status_reg_o), .dev_rd_idx_i(dev_rd_idx_i),
      .host_mbx_byte_o(host_mbx_byte_o), .dev_send_i(dev_send_i), .dev_status_i(dev_status_i),
      .dev_cw_i(dev_cw_i), .dev_mbx_we_i(dev_mbx_we_i), .dev_mbx_idx_i(dev_mbx_idx_i),
      .dev_mbx_data_i(dev_mbx_data_i), .dev_msg_pending_flag_o(dev_msg_pending_flag_o),
      .dev_send_ok_o(dev_send_ok_o), .op_channel_o(op_channel_o), .op_kind_o(op_kind_o),
      .ch1_route_o(ch1_route_o), .ch2_route_o(ch2_route_o), .ch1_frame_o(ch1_frame_o),
      .ch2_frame_o(ch2_frame_o));
   mbx_host u_mbx_host (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
      .wr_o(wr_i), .rd_o(rd_i));
   // ==========================================================
   // Helpers.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic take();
      @(posedge clk_i);
      dev_take_i <= 1'b1;
      @(posedge clk_i);
      dev_take_i <= 1'b0;
      #1;
   endtask : take
   task automatic print_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   // ==========================================================
   // Scenarios.
   task automatic t_host_msg();
      u_mbx_host.send_msg(8'h12, 16'h8302, 8'ha1, 8'hb2);
      chk("host flag", 16'h1, host_msg_pending_flag_o);
      chk("host cw", 16'h8302, host_cw_o);
      chk("op", 16'h1, {op_channel_o, op_kind_o});
      chk("host status", 16'h12, host_to_dev_status_reg_o);
      @(posedge clk_i);
      dev_rd_idx_i <= 6'h01;
      #1;
      chk("host mbx", 16'hb2, host_mbx_byte_o);
      take();
      chk("host flag", 16'h0, host_msg_pending_flag_o);
   endtask : t_host_msg
   task automatic t_config();
      for (int ch = 1; ch <= 2; ch++) begin
         for (int m = 0; m < 4; m++) begin
            u_mbx_host.send_msg(8'(ch << OP_CH_LSB), {4'h0, 2'(m), 2'(m), 8'h00}, 8'h0, 8'h0);
            take();
            if (ch == 1) begin
               chk("ch1 route", 16'(m), ch1_route_o);
               chk("ch1 frame", 16'(m), ch1_frame_o);
            end else begin
               chk("ch2 route", (m == 1) ? 16'h1 : 16'h3, ch2_route_o);
               chk("ch2 frame", 16'(m), ch2_frame_o);
            end
         end
      end
   endtask : t_config
   task automatic t_dev_msg();
      @(posedge clk_i);
      dev_mbx_we_i <= 1'b1;
      dev_mbx_data_i <= 8'h3c;
      @(posedge clk_i);
      dev_mbx_idx_i <= 6'h01;
      dev_mbx_data_i <= 8'h4d;
      @(posedge clk_i);
      dev_mbx_we_i <= 1'b0;
      dev_send_i <= 1'b1;
      dev_status_i <= 8'h55;
      dev_cw_i <= 16'h8102;
      // Send held high a second cycle with a new status: it must be refused.
      // A mailbox write while pending must be refused as well.
      @(posedge clk_i);
      dev_status_i <= 8'h66;
      dev_mbx_we_i <= 1'b1;
      dev_mbx_data_i <= 8'hee;
      @(posedge clk_i);
      dev_send_i <= 1'b0;
      dev_mbx_we_i <= 1'b0;
      #1;
      chk("irq masked", 16'h0, irq_o);
      chk("dev flag", 16'h1, dev_msg_pending_flag_o);
      chk("send ok", 16'h0, dev_send_ok_o);
      u_mbx_host.rd_reg(ADR_IRQ, d);
      chk("pending", 16'h4, d);
      u_mbx_host.rd_reg(ADR_DEV_STATUS, d);
      chk("dev status", 16'h55, d);
      u_mbx_host.rd_reg(ADR_DEV_CW_HI, d);
      chk("dev cw hi", 16'h81, d);
      u_mbx_host.rd_reg(ADR_DEV_CW_LO, d);
      chk("dev cw lo", 16'h02, d);
      u_mbx_host.wr_reg(ADR_RD_ADDR, 8'h00);
      u_mbx_host.rd_reg(ADR_MBX_DATA, d);
      u_mbx_host.rd_reg(ADR_MBX_DATA, d);
      chk("dev mbx", 16'h4d, d);
      u_mbx_host.wr_reg(ADR_IRQ, 8'h04);
      chk("irq on", 16'h1, irq_o);
      u_mbx_host.wr_reg(ADR_DEV_FLAG, 8'h00);
      chk("irq off", 16'h0, irq_o);
      chk("dev flag", 16'h0, dev_msg_pending_flag_o);
   endtask : t_dev_msg
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("irq reset", 16'h0, irq_o);
      u_mbx_host.rd_reg(8'h20, d);
      chk("unmapped", 16'h0, d);
      t_host_msg();
      t_config();
      t_dev_msg();
      print_verdict();
   end
   // The run needs a few hundred cycles; this limit leaves a wide margin.
   initial begin
      #100us;
      n_fail++;
      print_verdict();
   end
endmodule : tb_mbx_top
